// file: rtl/mab_pkg.sv
// Package with constants and types for the move and branch executor.
package mab_pkg;
    localparam int PC_W = 10;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int REG_DEPTH = 64;
    localparam logic [9:0] PC_RST = 10'h000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    localparam logic READY_RST = 1'b1;
    localparam logic [7:0] RD_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int BRANCH_CYCLES = 2;
    localparam int MOVE_CYCLES = 1;

    typedef enum logic [2:0] {
        MAB_OP_NONE = 3'b000,
        MAB_OP_LONG_BRANCH = 3'b001,
        MAB_OP_LOAD_IMM = 3'b010,
        MAB_OP_STORE_ACC = 3'b011,
        MAB_OP_MOVE_REG = 3'b100
    } mab_op_t;

    typedef enum logic [0:0] {
        MAB_ST_EXEC = 1'b0,
        MAB_ST_BRANCH2 = 1'b1
    } mab_state_t;
endpackage : mab_pkg

// file: rtl/mab_core.sv
// Executor for the long branch and three data move instructions.
// Notes on behaviour
// RQ1: long branch loads 10-bit target, two cycles
// RQ2: load immediate writes accumulator, flags untouched
// RQ3: store accumulator to register, one cycle
// RQ4: register move to accumulator or register
// RQ5: register move sets zero flag on zero
// RQ6: load immediate completes in one cycle
`timescale 1ns/10ps
module mab_core (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // Decoded instruction.
    input wire logic instr_valid_i,
    input wire logic [2:0] instr_op_i,
    input wire logic [9:0] instr_target_i,
    input wire logic [7:0] instr_imm_i,
    input wire logic [5:0] instr_addr_i,
    input wire logic instr_dest_i,
    // Core state.
    output logic ready_o,
    output logic [9:0] pc_o,
    output logic [7:0] accumulator_o,
    output logic zero_flag_o,
    output logic [7:0] reg_rd_data_o
);
    logic [7:0] regs_ff [mab_pkg::REG_DEPTH];
    logic [7:0] nxt_regs [mab_pkg::REG_DEPTH];
    logic [9:0] pc_ff;
    logic [9:0] nxt_pc;
    logic [7:0] acc_ff;
    logic [7:0] nxt_acc;
    logic zero_ff;
    logic nxt_zero;
    logic ready_ff;
    logic nxt_ready;
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;
    mab_pkg::mab_state_t state_ff;
    mab_pkg::mab_state_t nxt_state;
    logic [7:0] rd_val;
    logic take;

    assign rd_val = regs_ff[instr_addr_i];
    assign take = instr_valid_i && (state_ff == mab_pkg::MAB_ST_EXEC);

    // Next state for program counter, accumulator, flag and registers.
    always_comb begin
        nxt_pc = pc_ff;
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        nxt_regs = regs_ff;
        nxt_state = state_ff;
        nxt_ready = 1'b1;
        nxt_rd = rd_ff;
        case (state_ff)
            mab_pkg::MAB_ST_BRANCH2: begin
                nxt_state = mab_pkg::MAB_ST_EXEC;
            end
            mab_pkg::MAB_ST_EXEC: begin
                if (take) begin
                    case (instr_op_i)
                        mab_pkg::MAB_OP_LONG_BRANCH: begin
                            nxt_pc = instr_target_i; // RQ1
                            nxt_state = mab_pkg::MAB_ST_BRANCH2; // RQ1
                            nxt_ready = 1'b0; // RQ1
                        end
                        mab_pkg::MAB_OP_LOAD_IMM: begin
                            nxt_acc = instr_imm_i; // RQ2
                            nxt_pc = pc_ff + 10'h001; // RQ6
                        end
                        mab_pkg::MAB_OP_STORE_ACC: begin
                            nxt_regs[instr_addr_i] = acc_ff; // RQ3
                            nxt_pc = pc_ff + 10'h001; // RQ3
                        end
                        mab_pkg::MAB_OP_MOVE_REG: begin
                            if (instr_dest_i) begin
                                nxt_regs[instr_addr_i] = rd_val; // RQ4
                            end else begin
                                nxt_acc = rd_val; // RQ4
                            end
                            nxt_rd = rd_val;
                            nxt_zero = (rd_val == 8'h00); // RQ5
                            nxt_pc = pc_ff + 10'h001; // RQ4
                        end
                        default: begin
                            nxt_pc = pc_ff + 10'h001;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state = mab_pkg::MAB_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pc_ff <= mab_pkg::PC_RST;
            acc_ff <= mab_pkg::ACC_RST;
            zero_ff <= mab_pkg::ZERO_RST;
            state_ff <= mab_pkg::MAB_ST_EXEC;
            ready_ff <= mab_pkg::READY_RST;
            rd_ff <= mab_pkg::RD_RST;
            for (int i = 0; i < mab_pkg::REG_DEPTH; i++) begin
                regs_ff[i] <= mab_pkg::REG_RST;
            end
        end else begin
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
            state_ff <= nxt_state;
            ready_ff <= nxt_ready;
            rd_ff <= nxt_rd;
            regs_ff <= nxt_regs;
        end
    end

    assign ready_o = ready_ff;
    assign pc_o = pc_ff;
    assign accumulator_o = acc_ff;
    assign zero_flag_o = zero_ff;
    assign reg_rd_data_o = rd_ff;

    sequence branch_s;
        take && instr_op_i == mab_pkg::MAB_OP_LONG_BRANCH;
    endsequence

    branch_target_a: assert property (@(posedge clock_i) // RQ1
        disable iff (sys_rst_i)
        branch_s |=> pc_ff == $past(instr_target_i) && !ready_ff
            ##1 ready_ff && state_ff == mab_pkg::MAB_ST_EXEC)
        else $error("long branch target or timing wrong");

    branch_flags_a: assert property (@(posedge clock_i) // RQ1
        disable iff (sys_rst_i)
        branch_s |=> $stable(zero_ff) && $stable(acc_ff))
        else $error("long branch altered state");

    load_imm_a: assert property (@(posedge clock_i) // RQ2
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_LOAD_IMM
            |=> acc_ff == $past(instr_imm_i) && $stable(zero_ff))
        else $error("load immediate wrong");

    load_imm_cycle_a: assert property (@(posedge clock_i) // RQ6
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_LOAD_IMM
            |=> ready_ff && pc_ff == $past(pc_ff) + 10'h001)
        else $error("load immediate not one cycle");

    store_acc_a: assert property (@(posedge clock_i) // RQ3
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_STORE_ACC
            |=> regs_ff[$past(instr_addr_i)] == $past(acc_ff)
                && $stable(zero_ff) && ready_ff)
        else $error("store accumulator wrong");

    move_acc_a: assert property (@(posedge clock_i) // RQ4
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_MOVE_REG && !instr_dest_i
            |=> acc_ff == $past(rd_val) && ready_ff)
        else $error("move to accumulator wrong");

    move_reg_a: assert property (@(posedge clock_i) // RQ4
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_MOVE_REG && instr_dest_i
            |=> regs_ff[$past(instr_addr_i)] == $past(rd_val)
                && $stable(acc_ff))
        else $error("move to register wrong");

    move_zero_a: assert property (@(posedge clock_i) // RQ5
        disable iff (sys_rst_i)
        take && instr_op_i == mab_pkg::MAB_OP_MOVE_REG
            |=> zero_ff == ($past(rd_val) == 8'h00))
        else $error("zero flag wrong after move");

    sequence load_s;
        take && instr_op_i == mab_pkg::MAB_OP_LOAD_IMM;
    endsequence

    sequence store_s;
        take && instr_op_i == mab_pkg::MAB_OP_STORE_ACC;
    endsequence

    sequence move_s;
        take && instr_op_i == mab_pkg::MAB_OP_MOVE_REG;
    endsequence

    busy_hold_a: assert property (@(posedge clock_i) // RQ1
        disable iff (sys_rst_i)
        !ready_ff |=> $stable(pc_ff) && $stable(acc_ff) && $stable(zero_ff))
        else $error("state changed during dead cycle");

    branch_dead_a: assert property (@(posedge clock_i) // RQ1
        disable iff (sys_rst_i)
        branch_s |=> ##1 $stable(pc_ff))
        else $error("program counter moved in dead cycle");

    dead_cycle_a: assert property (@(posedge clock_i) // RQ1
        disable iff (sys_rst_i)
        state_ff == mab_pkg::MAB_ST_BRANCH2
            |=> state_ff == mab_pkg::MAB_ST_EXEC && ready_ff)
        else $error("dead cycle longer than one");

    load_rd_a: assert property (@(posedge clock_i) // RQ2
        disable iff (sys_rst_i)
        load_s |=> $stable(rd_ff) && $stable(zero_ff))
        else $error("load immediate touched other state");

    store_cycle_a: assert property (@(posedge clock_i) // RQ3
        disable iff (sys_rst_i)
        store_s |=> ready_ff && pc_ff == $past(pc_ff) + 10'h001
            && $stable(acc_ff))
        else $error("store accumulator not one cycle");

    move_cycle_a: assert property (@(posedge clock_i) // RQ4
        disable iff (sys_rst_i)
        move_s |=> ready_ff && pc_ff == $past(pc_ff) + 10'h001
            && rd_ff == $past(rd_val))
        else $error("register move not one cycle");
endmodule : mab_core

// file: testbench/mab_prog_mem.sv
// Program memory model that offers one instruction at a time to the core.
`timescale 1ns/10ps
module mab_prog_mem (
    // Clock and handshake.
    input wire logic clock_i,
    input wire logic ready_i,
    // Instruction fields.
    output logic valid_o = 1'b0,
    output logic [2:0] op_o = 3'h0,
    output logic [9:0] target_o = 10'h000,
    output logic [7:0] imm_o = 8'h00,
    output logic [5:0] addr_o = 6'h00,
    output logic dest_o = 1'b0
);
    // Holds the instruction until an edge that sees ready high.
    task automatic issue(input logic [27:0] ins);
        {op_o, target_o, imm_o, addr_o, dest_o} = ins;
        valid_o = 1'b1;
        do @(posedge clock_i); while (ready_i !== 1'b1);
        #1;
    endtask : issue
    // Drops the request and scrambles the stale fields.
    task automatic idle();
        valid_o = 1'b0;
        {op_o, target_o, imm_o, addr_o, dest_o} = ~{op_o, target_o, imm_o,
            addr_o, dest_o};
    endtask : idle
endmodule : mab_prog_mem

// file: testbench/mab_core_tb.sv
// Self-checking bench for the move and branch executor.
`timescale 1ns/10ps
module mab_core_tb;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, taken_ff = 1'b0;
    logic instr_valid_i, instr_dest_i, ready_o, zero_flag_o, e_z = 1'b0;
    logic [2:0] instr_op_i;
    logic [9:0] instr_target_i, pc_o, e_pc = 10'h000;
    logic [7:0] instr_imm_i, accumulator_o, reg_rd_data_o, lf = 8'h13;
    logic [7:0] e_acc = 8'h00, e_rd = 8'h00, rf [64];
    logic [5:0] instr_addr_i;
    logic [26:0] exp_q [$];
    int error_cnt = 0, n_tests = 0;
    always #25 clock_i = ~clock_i;
    mab_core mab_core_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
        .instr_target_i(instr_target_i), .instr_imm_i(instr_imm_i),
        .instr_addr_i(instr_addr_i), .instr_dest_i(instr_dest_i),
        .ready_o(ready_o), .pc_o(pc_o), .accumulator_o(accumulator_o),
        .zero_flag_o(zero_flag_o), .reg_rd_data_o(reg_rd_data_o));
    mab_prog_mem mab_prog_mem_inst (.clock_i(clock_i), .ready_i(ready_o),
        .valid_o(instr_valid_i), .op_o(instr_op_i),
        .target_o(instr_target_i), .imm_o(instr_imm_i),
        .addr_o(instr_addr_i), .dest_o(instr_dest_i));
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [26:0] e, g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("Errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // Updates the expected state, queues it and hands the instruction over.
    task automatic do_op(input logic [2:0] op, input logic [9:0] tg,
        input logic [7:0] im, input logic [5:0] ad, input logic de);
        case (op)
            3'h1: e_pc = tg;
            3'h2: e_acc = im;
            3'h3: rf[ad] = e_acc;
            3'h4: begin
                e_rd = rf[ad];
                e_z = (rf[ad] === 8'h00);
                if (!de) e_acc = rf[ad];
            end
            default: ;
        endcase
        if (op != 3'h1) e_pc = e_pc + 10'h001;
        exp_q.push_back({e_pc, e_acc, e_z, e_rd});
        mab_prog_mem_inst.issue({op, tg, im, ad, de});
        if (op == 3'h1) chk("ready", 27'h0, {26'h0, ready_o});
    endtask : do_op
    always @(posedge clock_i) taken_ff <= instr_valid_i & ready_o & ~sys_rst_i;
    always @(negedge clock_i) if (taken_ff) chk("state", exp_q.size() != 0 ?
        exp_q.pop_front() : 27'hx, {pc_o, accumulator_o, zero_flag_o,
        reg_rd_data_o});
    initial begin
        #(50 * 5000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        foreach (rf[i]) rf[i] = 8'h00;
        repeat (10) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        chk("reset", 27'h080, {pc_o, accumulator_o, zero_flag_o, ready_o,
            reg_rd_data_o[7:1]});
        for (int i = 0; i < 64; i++) begin
            lf = nxt(lf);
            do_op(3'h2, {lf[1:0], lf}, (i == 9) ? 8'h00 : lf, ~lf[5:0], 1'b0);
            do_op(3'h3, {lf, lf[1:0]}, ~lf, i[5:0], lf[0]);
        end
        for (int i = 0; i < 128; i++) begin
            lf = nxt(lf);
            do_op(3'h4, {lf[1:0], lf}, lf, i[5:0] ^ 6'h15, i[6]);
        end
        foreach (rf[i]) do_op(3'h1, (i < 2) ? {10{i[0]}} : {lf, lf[3:2]},
            lf, 6'h09, 1'b1);
        do_op(3'h0, 10'h2aa, 8'h5a, 6'h2a, 1'b1);
        do_op(3'h7, 10'h155, 8'ha5, 6'h15, 1'b0);
        mab_prog_mem_inst.idle();
        repeat (3) @(posedge clock_i);
        chk("queue", 27'h0, 27'(exp_q.size()));
        report_and_stop();
    end
endmodule : mab_core_tb
